// file: verilog/itp_regs.svh
// Register map and reset values of the prescaled interval timer.
// Assumes a word-indexed plain register port with 4-bit address.
`ifndef ITP_REGS_SVH
`define ITP_REGS_SVH
`define ITP_ADDR_W 4
`define ITP_OFS_COUNT 4'h0
`define ITP_OFS_SCALE 4'h1
`define ITP_OFS_PERIOD 4'h2
`define ITP_OFS_CTRL 4'h3
`define ITP_OFS_STATUS 4'h4
`define ITP_CTRL_EN_BIT 0
`define ITP_STATUS_EXP_BIT 0
`define ITP_RST_COUNT 16'h0000
`define ITP_RST_SCALE 8'h00
`define ITP_RST_PERIOD 16'h0000
`endif

// file: verilog/itp_pkg.sv
// Types shared by the interval timer.
// Assumes the register header is included by the design file.
package itp_pkg;
  typedef logic [15:0] itp_count_t;
  typedef logic [7:0] itp_scale_t;
endpackage : itp_pkg

// file: verilog/itp_timer.sv
// Prescaled 16-bit interval timer with a plain register port.
// Assumes one clock, synchronous active-high reset, same-domain bus master.
// Functional notes
// [R1] Timer count is a 16-bit register that counts downward.
// [R2] Count decrements once every prescale plus one cycles.
// [R3] Prescale value is an 8-bit software-writable register.
// [R4] Interrupt request is raised when the count reaches zero; the code raises it on the step from one and not for a zero count.
// [R5] On reaching zero the count reloads from the 16-bit period register.
// [R6] Interrupt request goes to the processor interrupt controller input.
// [R7] Separate prescale down-counter reloads on expiry; each expiry decrements count.
`timescale 1ns/1ps
`include "itp_regs.svh"

// Reloading down-counter shared by the prescaler and the main count
module itp_down_cnt #(
  parameter int W = 8,
  parameter int LAST = 0,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic step,
  input wire logic [W-1:0] reload_val,
  output logic [W-1:0] value_q,
  output logic wrap
);
  // A step at or below the last value reloads instead of counting on
  assign wrap = (value_q <= W'(LAST));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      value_q <= RST_VAL;
    end else if (load) begin
      value_q <= load_val;
    end else if (step) begin
      if (wrap) begin
        value_q <= reload_val;
      end else begin
        value_q <= value_q - W'(1);
      end
    end
  end
endmodule : itp_down_cnt

// Software register with a write-enabled load
module itp_sw_reg #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic [W-1:0] value_q
);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      value_q <= RST_VAL;
    end else if (load) begin
      value_q <= load_val;
    end
  end
endmodule : itp_sw_reg

module itp_timer (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`ITP_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic timer_irq
);
  itp_pkg::itp_count_t count_q;
  itp_pkg::itp_count_t period_q;
  itp_pkg::itp_scale_t scale_q;
  itp_pkg::itp_scale_t pre_q;
  logic [15:0] rdata_d;
  logic enable_q;
  logic expired_q;
  logic tick;
  logic pre_wrap;
  logic pre_load;
  logic hit_zero;
  logic wr_count;
  logic wr_scale;
  logic wr_period;
  logic wr_ctrl;
  logic wr_status;
  logic clr_status;

  // Register map, one word per index
  // Count: 16 bits, a write loads it and restarts the prescaler
  // Scale: 8 bits, upper read bits are zero
  // Period: 16 bits, taken on the step from one
  // Control: bit 0 enables counting
  // Status: bit 0 set by a request, writing one clears it
  // Requests recur every period times scale plus one cycles
  // A zero count steps to the period without a request
  always_comb begin
    wr_count = 1'b0;
    wr_scale = 1'b0;
    wr_period = 1'b0;
    wr_ctrl = 1'b0;
    wr_status = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        `ITP_OFS_COUNT: wr_count = 1'b1;
        `ITP_OFS_SCALE: wr_scale = 1'b1;
        `ITP_OFS_PERIOD: wr_period = 1'b1;
        `ITP_OFS_CTRL: wr_ctrl = 1'b1;
        `ITP_OFS_STATUS: wr_status = 1'b1;
        default: ;
      endcase
    end
  end
  assign clr_status = wr_status && reg_wdata[`ITP_STATUS_EXP_BIT];

  itp_sw_reg #(
    .W(8),
    .RST_VAL(`ITP_RST_SCALE)
  ) u_scale (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(wr_scale),
    .load_val(reg_wdata[7:0]), // [R3]
    .value_q(scale_q)
  );

  itp_sw_reg #(
    .W(16),
    .RST_VAL(`ITP_RST_PERIOD)
  ) u_period (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(wr_period),
    .load_val(reg_wdata), // [R5]
    .value_q(period_q)
  );

  itp_sw_reg #(
    .W(1),
    .RST_VAL(1'b0)
  ) u_enable (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(wr_ctrl),
    .load_val(reg_wdata[`ITP_CTRL_EN_BIT]),
    .value_q(enable_q)
  );

  // Stopped or freshly written timer restarts a full prescale interval
  assign pre_load = !enable_q || wr_count; // [R7]
  // Prescaler expiry gives one count step
  assign tick = enable_q && pre_wrap; // [R7] [R2]

  itp_down_cnt #(
    .W(8),
    .LAST(0),
    .RST_VAL(`ITP_RST_SCALE)
  ) u_pre (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(pre_load),
    .load_val(scale_q),
    .step(enable_q),
    .reload_val(scale_q), // [R7]
    .value_q(pre_q),
    .wrap(pre_wrap)
  );

  // Zero is held while running only with a zero period: the step from one reloads at once
  itp_down_cnt #(
    .W(16),
    .LAST(1),
    .RST_VAL(`ITP_RST_COUNT)
  ) u_count (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(wr_count),
    .load_val(reg_wdata),
    .step(tick), // [R1] [R2]
    .reload_val(period_q), // [R5]
    .value_q(count_q),
    .wrap()
  );

  // A count write in the same cycle overrides the step, so no request
  assign hit_zero = tick && !wr_count && (count_q == 16'h0001); // [R4]

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= hit_zero; // [R4] [R6]
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      expired_q <= 1'b0;
    end else if (hit_zero) begin
      expired_q <= 1'b1; // [R4]
    end else if (clr_status) begin
      expired_q <= 1'b0;
    end
  end

  // Idle cycles and unmapped addresses read as zero
  always_comb begin
    rdata_d = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `ITP_OFS_COUNT: rdata_d = count_q; // [R1]
        `ITP_OFS_SCALE: rdata_d = {8'h00, scale_q}; // [R3]
        `ITP_OFS_PERIOD: rdata_d = period_q; // [R5]
        `ITP_OFS_CTRL: rdata_d = {15'h0, enable_q};
        `ITP_OFS_STATUS: rdata_d = {15'h0, expired_q}; // [R4]
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= rdata_d;
    end
  end
endmodule : itp_timer

// file: bench/itp_sva.sv
// Port checker of itp_timer.
// Assumes one clock and the bind at the foot.
`timescale 1ns/1ps
module itp_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic timer_irq,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_cnt_rw: assert property (reg_wr && reg_addr == 0 && reg_wdata > 2
    ##1 reg_rd && reg_addr == 0 |=> $past(reg_wdata, 2) - reg_rdata <= 1) else $error("count");
  chk_cnt_gap: assert property (reg_wr && reg_addr == 0 && reg_wdata > 1
    |=> ##1 !timer_irq) else $error("early irq");
  chk_scl_rd: assert property (reg_wr && reg_addr == 1 ##1 reg_rd && reg_addr == 1
    |=> reg_rdata == ($past(reg_wdata, 2) & 16'h00ff)) else $error("scale");
  chk_irq_sts: assert property (timer_irq && !reg_wr ##1 reg_rd && reg_addr == 4
    |=> reg_rdata[0]) else $error("status");
  chk_rst_irq: assert property (disable iff (1'b0) sys_rst |=> !timer_irq)
    else $error("reset");
  chk_per_rd: assert property (reg_wr && reg_addr == 2 ##1 reg_rd && reg_addr == 2
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("period");
  chk_sts_clr: assert property (reg_wr && reg_addr == 4 && reg_wdata[0]
    ##1 !timer_irq && reg_rd && reg_addr == 4 |=> !reg_rdata[0]) else $error("clear");
  cover property (timer_irq);
  cover property (reg_rd && reg_addr == 4);
  cover property (reg_wr && reg_addr == 3);
  cover property (reg_wr && reg_addr == 4 && reg_wdata[0]);
endmodule : itp_sva
bind itp_timer itp_sva u_sva (.clk, .sys_rst, .reg_wr, .reg_rd, .timer_irq, .reg_addr,
  .reg_wdata, .reg_rdata);

// file: bench/itp_timer_tb.sv
// Bench of itp_timer over its register port.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
module itp_timer_tb;
  logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, timer_irq;
  logic [3:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata;
  int n_errors = 0, cmp_count = 0, n;
  always #50 clk = ~clk;
  itp_timer dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .timer_irq);
  task chk(input logic [15:0] s, e);
    cmp_count++;
    if (s !== e) n_errors++;
    if (s !== e) $display("BAD %0t %h %h", $time, s, e);
  endtask : chk
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_wr <= 0;
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    #1 chk(reg_rdata, e);
  endtask : rd
  task wrd(input logic [3:0] a, input logic [15:0] d, e);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    rd(a, e);
  endtask : wrd
  // Sync to one request, then count cycles to the next
  task irq_gap(input logic [15:0] e);
    repeat (2) begin
      n = 1;
      do @(negedge clk); while (timer_irq !== 1 && ++n < 99);
    end
    chk(16'(n), e);
  endtask : irq_gap
  task end_sim;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  initial begin
    #100000 n_errors++;
    end_sim;
  end
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 0;
    for (int i = 0; i < 8; i++) rd(4'(i), 16'h0000);
    wrd(4'h1, 16'hff02, 16'h0002);
    wrd(4'h2, 16'h0003, 16'h0003);
    wrd(4'h0, 16'h0005, 16'h0005);
    wrd(4'h3, 16'h0001, 16'h0001);
    // Period 3 times scale 2 plus one
    irq_gap(16'h0009);
    rd(4'h4, 16'h0001);
    wrd(4'h4, 16'h0001, 16'h0000);
    // Reset in mid-run clears the registers
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(4'h3, 16'h0000);
    rd(4'h1, 16'h0000);
    rd(4'h0, 16'h0000);
    // Prescale zero steps every cycle, so the gap equals the period
    wrd(4'h2, 16'h0004, 16'h0004);
    wrd(4'h0, 16'h0004, 16'h0004);
    wrd(4'h3, 16'h0001, 16'h0001);
    irq_gap(16'h0004);
    end_sim;
  end
endmodule : itp_timer_tb
